/* File: ppaf_assertions.sv */
// Purpose: port checks of the pin override block
// Assumes: register copies rebuilt from APB writes
// Notes:   bound into ppaf_top
`timescale 1ns/100ps
`include "ppaf_cfg.svh"
module ppaf_assertions (
   input wire logic        clk_i,
   input wire logic        reset_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        sleep_i,
   input wire logic [7:0]  pad_in_i,
   input wire logic [7:0]  pad_out_o,
   input wire logic [7:0]  pad_oe_o,
   input wire logic [7:0]  pullup_en_o,
   input wire logic [7:0]  input_en_o,
   input wire logic [7:0]  pullup_override_enable_i,
   input wire logic [7:0]  pullup_override_value_i,
   input wire logic [7:0]  direction_override_enable_i,
   input wire logic [7:0]  direction_override_value_i,
   input wire logic [7:0]  pin_value_override_enable_i,
   input wire logic [7:0]  pin_value_override_value_i,
   input wire logic [7:0]  input_enable_override_enable_i,
   input wire logic [7:0]  input_enable_override_value_i,
   input wire logic [7:0]  alt_function_digital_in_o,
   input wire logic        xmem_write_strobe_i,
   input wire logic        address_phase_active_i,
   input wire logic [7:0]  xmem_addr_low_i,
   input wire logic [7:0]  xmem_data_out_i,
   input wire logic [7:0]  xmem_data_in_o
);
   logic [7:0] dir_reg, out_reg;
   logic [2:0] ctl_reg;
   wire        wr_en = psel_i & penable_i & pready_o & pwrite_i;
   wire        xm    = ctl_reg[`PPAF_CTRL_XMEM];
   wire        global_pullup_disable   = ctl_reg[`PPAF_CTRL_PUD];
   wire        awake = !(ctl_reg[`PPAF_CTRL_SLEEP] | sleep_i);
   wire        bus   = xmem_write_strobe_i | address_phase_active_i;
   wire [7:0]  direction_override_enable  = direction_override_enable_i;
   wire [7:0]  pin_value_override_enable  = pin_value_override_enable_i;
   wire [7:0]  ieoe  = input_enable_override_enable_i;
   wire [7:0]  drv   = direction_override_enable & direction_override_value_i | ~direction_override_enable & dir_reg;
   wire [7:0]  val   = (pin_value_override_enable & pin_value_override_value_i | ~pin_value_override_enable & out_reg) & drv;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         dir_reg <= 8'h00;
         out_reg <= 8'h00;
         ctl_reg <= 3'h0;
      end else if (wr_en) begin
         if (paddr_i == `PPAF_OFS_DIR) dir_reg <= pwdata_i[7:0];
         if (paddr_i == `PPAF_OFS_OUT) out_reg <= pwdata_i[7:0];
         if (paddr_i == `PPAF_OFS_CTRL) ctl_reg <= pwdata_i[2:0];
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   sequence s_setup; psel_i && !penable_i; endsequence
   sequence s_answer; pready_o ##1 !pready_o; endsequence
   chk_apb_ready: assert property (s_setup |=> s_answer) else $error("pready not one cycle after setup");
   chk_apb_unmapped: assert property (s_setup |=> pslverr_o == $past(paddr_i[1:0] != 2'b00 || paddr_i > `PPAF_OFS_STATE))
      else $error("pslverr wrong for address");
   chk_pullup_norm: assert property (!xm |=> (pullup_en_o & ~$past(pullup_override_enable_i)) ==
      $past(~dir_reg & out_reg & {8{!global_pullup_disable}} & ~pullup_override_enable_i)) else $error("plain pull-up wrong");
   chk_pullup_ovr: assert property (!xm |=> (pullup_en_o & $past(pullup_override_enable_i)) ==
      $past(pullup_override_enable_i & pullup_override_value_i)) else $error("pull-up override wrong");
   chk_drive_ovr: assert property (!xm |=> pad_oe_o == $past(drv)) else $error("driver enable wrong");
   chk_value_ovr: assert property (!xm |=> pad_out_o == $past(val)) else $error("pin level wrong");
   chk_input_ovr: assert property (!xm |=> input_en_o == $past(ieoe & input_enable_override_value_i
      | ~ieoe & {8{awake}})) else $error("input enable wrong");
   chk_xmem_drive: assert property (xm |=> pad_oe_o == {8{$past(bus)}} && input_en_o == {8{$past(awake)}})
      else $error("bus driver enable wrong");
   chk_xmem_value: assert property (xm |=> pad_out_o == $past({8{address_phase_active_i}} & xmem_addr_low_i
      | {8{xmem_write_strobe_i}} & xmem_data_out_i)) else $error("bus pin level wrong");
   chk_xmem_pullup: assert property (xm |=> pullup_en_o == $past(out_reg & {8{!(bus | global_pullup_disable)}}))
      else $error("bus pull-up wrong");
   chk_din_gate: assert property ($stable(input_en_o) |-> alt_function_digital_in_o ==
      ($past(pad_in_i) & input_en_o) && xmem_data_in_o == alt_function_digital_in_o) else $error("input path wrong");
endmodule
bind ppaf_top ppaf_assertions ppaf_assertions_i (.*);

/* File: ppaf_cfg.svh */
// Purpose: constants for the port pin alternate function override block
// Assumes: one 8-pin port, APB register access
// Notes:   byte addresses of the APB registers
`ifndef PPAF_CFG_SVH
`define PPAF_CFG_SVH
`define PPAF_PINS        8
`define PPAF_OFS_DIR     12'h000
`define PPAF_OFS_OUT     12'h004
`define PPAF_OFS_PIN     12'h008
`define PPAF_OFS_CTRL    12'h00C
`define PPAF_OFS_STATE   12'h010
`define PPAF_CTRL_PUD    0
`define PPAF_CTRL_SLEEP  1
`define PPAF_CTRL_XMEM   2
`define PPAF_RST_BYTE    8'h00
`endif

/* File: ppaf_pin.sv */
// Purpose: one pin's override resolution
// Assumes: override inputs are synchronous to the clock
// Notes:   combinational; the top registers its results
`timescale 1ns/100ps
module ppaf_pin
   import ppaf_pkg::*;
(
   input  wire logic pin_direction_bit_i,
   input  wire logic pin_output_bit_i,
   input  wire logic global_pullup_disable_i,
   input  wire logic sleep_i,
   input  wire logic pullup_override_enable_i,
   input  wire logic pullup_override_value_i,
   input  wire logic direction_override_enable_i,
   input  wire logic direction_override_value_i,
   input  wire logic pin_value_override_enable_i,
   input  wire logic pin_value_override_value_i,
   input  wire logic input_enable_override_enable_i,
   input  wire logic input_enable_override_value_i,
   output      logic pullup_o,
   output      logic drive_en_o,
   output      logic drive_val_o,
   output      logic input_en_o
);
   wire logic normal_pullup;
   assign normal_pullup = ~pin_direction_bit_i & pin_output_bit_i & ~global_pullup_disable_i;
   assign pullup_o      = pullup_override_enable_i ? pullup_override_value_i : normal_pullup;
   assign drive_en_o    = direction_override_enable_i ? direction_override_value_i
                                                      : pin_direction_bit_i;
   assign drive_val_o   = pin_value_override_enable_i ? pin_value_override_value_i
                                                      : pin_output_bit_i;
   assign input_en_o    = input_enable_override_enable_i ? input_enable_override_value_i
                                                         : ~sleep_i;
endmodule

/* File: ppaf_pkg.sv */
// Purpose: shared types for the port pin alternate function override block
// Assumes: nothing beyond the constants header
// Notes:   types only
package ppaf_pkg;
   typedef logic [7:0] ppaf_byte_t;
   typedef enum logic [1:0] {PPAF_IDLE, PPAF_ACCESS} ppaf_apb_state_t;
endpackage

/* File: ppaf_top.sv */
// Purpose: port pin alternate function override for one 8-pin port (port A)
// Assumes: clk_i 50 MHz, reset_i synchronous active high, pins synchronous
// Notes:   registers over APB; external memory mapping of port A built in
//
// Functional notes
// - pull-up override enable selects the override value for pull-up.
// - without override, pull-up on when direction 0, output 1, global disable 0.
// - override value 1 turns pull-up on, 0 off, ignoring register bits.
// - direction override enable selects driver enable from override value, else direction bit.
// - direction override value 1 enables driver, 0 disables it.
// - enabled driver outputs override value if its enable set, else output bit.
// - pin value override forces output level to override value.
// - input enable override enable takes input enable from override value.
// - without override, input enable follows normal versus sleep state.
// - input enable override value 1 enables, 0 disables, regardless of sleep.
// - analog path connects straight to the pad, both directions.
// - port strobes shared per port; clock, sleep, pull-up disable global; overrides per pin.
// - port A pin n carries external memory address/data bit n.
// - external memory enable drives pull-up, direction, value override enables; input override 0.
// - driver enabled during write strobe or address phase, else input.
// - direction 1 is output, 0 input; input with output bit 1 enables pull-up.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/100ps
`include "ppaf_cfg.svh"
module ppaf_top
   import ppaf_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output      logic [31:0] prdata_o,
   output      logic        pready_o,
   output      logic        pslverr_o,
   input  wire logic        sleep_i,
   input  wire logic [7:0]  pad_in_i,
   output      logic [7:0]  pad_out_o,
   output      logic [7:0]  pad_oe_o,
   output      logic [7:0]  pullup_en_o,
   output      logic [7:0]  input_en_o,
   input  wire logic [7:0]  pullup_override_enable_i,
   input  wire logic [7:0]  pullup_override_value_i,
   input  wire logic [7:0]  direction_override_enable_i,
   input  wire logic [7:0]  direction_override_value_i,
   input  wire logic [7:0]  pin_value_override_enable_i,
   input  wire logic [7:0]  pin_value_override_value_i,
   input  wire logic [7:0]  input_enable_override_enable_i,
   input  wire logic [7:0]  input_enable_override_value_i,
   output      logic [7:0]  alt_function_digital_in_o,
   input  wire logic        xmem_write_strobe_i,
   input  wire logic        address_phase_active_i,
   input  wire logic [7:0]  xmem_addr_low_i,
   input  wire logic [7:0]  xmem_data_out_i,
   output      logic [7:0]  xmem_data_in_o
);
   ppaf_byte_t dir_reg;
   ppaf_byte_t out_reg;
   ppaf_byte_t pin_sync0_reg;
   ppaf_byte_t pin_sync_reg;
   logic [2:0] ctrl_reg;
   logic [31:0] prdata_reg;
   logic       pready_reg;
   logic       pslverr_reg;
   ppaf_byte_t pad_out_reg;
   ppaf_byte_t pad_oe_reg;
   ppaf_byte_t pullup_reg;
   ppaf_byte_t inen_reg;
   ppaf_byte_t di_reg;
   ppaf_apb_state_t apb_state_reg;
   ppaf_apb_state_t apb_state_next;

   // global signals shared by every pin
   wire logic global_pullup_disable;
   wire logic xmem_en;
   wire logic sleep_any;
   assign global_pullup_disable       = ctrl_reg[`PPAF_CTRL_PUD];
   assign xmem_en   = ctrl_reg[`PPAF_CTRL_XMEM];
   assign sleep_any = sleep_i | ctrl_reg[`PPAF_CTRL_SLEEP];

   // external memory bus request for the pins
   wire logic xmem_drive;
   assign xmem_drive = xmem_write_strobe_i | address_phase_active_i;

   ppaf_byte_t res_pullup;
   ppaf_byte_t res_oe;
   ppaf_byte_t res_val;
   ppaf_byte_t res_inen;

   genvar n;
   generate
      for (n = 0; n < `PPAF_PINS; n++) begin : g_pin
         wire logic pullup_override_enable;
         wire logic pullup_override_value;
         wire logic direction_override_enable;
         wire logic direction_override_value;
         wire logic pin_value_override_enable;
         wire logic pin_value_override_value;
         wire logic ieoe;
         wire logic ieov;
         // external memory enable takes all three output overrides
         assign pullup_override_enable = xmem_en | pullup_override_enable_i[n];
         assign pullup_override_value = xmem_en ? (~xmem_drive & out_reg[n] & ~global_pullup_disable) : pullup_override_value_i[n];
         assign direction_override_enable = xmem_en | direction_override_enable_i[n];
         assign direction_override_value = xmem_en ? xmem_drive : direction_override_value_i[n];
         assign pin_value_override_enable = xmem_en | pin_value_override_enable_i[n];
         assign pin_value_override_value = xmem_en ? ((xmem_addr_low_i[n] & address_phase_active_i) |
                                  (xmem_data_out_i[n] & xmem_write_strobe_i))
                               : pin_value_override_value_i[n];
         assign ieoe = xmem_en ? 1'b0 : input_enable_override_enable_i[n];
         assign ieov = xmem_en ? 1'b0 : input_enable_override_value_i[n];
         ppaf_pin u_pin (
            .pin_direction_bit_i            (dir_reg[n]),
            .pin_output_bit_i               (out_reg[n]),
            .global_pullup_disable_i        (global_pullup_disable),
            .sleep_i                        (sleep_any),
            .pullup_override_enable_i       (pullup_override_enable),
            .pullup_override_value_i        (pullup_override_value),
            .direction_override_enable_i    (direction_override_enable),
            .direction_override_value_i     (direction_override_value),
            .pin_value_override_enable_i    (pin_value_override_enable),
            .pin_value_override_value_i     (pin_value_override_value),
            .input_enable_override_enable_i (ieoe),
            .input_enable_override_value_i  (ieov),
            .pullup_o                       (res_pullup[n]),
            .drive_en_o                     (res_oe[n]),
            .drive_val_o                    (res_val[n]),
            .input_en_o                     (res_inen[n])
         );
      end
   endgenerate

   // a disabled input is clamped low before reaching anyone
   ppaf_byte_t gated_in;
   assign gated_in = pad_in_i & inen_reg;

   // APB decode
   wire logic setup_phase;
   wire logic access_phase;
   wire logic wr_en;
   wire logic hit_dir;
   wire logic hit_out;
   wire logic hit_pin;
   wire logic hit_ctrl;
   wire logic hit_state;
   wire logic hit_any;
   assign setup_phase  = psel_i & ~penable_i;
   assign access_phase = psel_i & penable_i & (apb_state_reg == PPAF_ACCESS);
   assign hit_dir      = paddr_i == `PPAF_OFS_DIR;
   assign hit_out      = paddr_i == `PPAF_OFS_OUT;
   assign hit_pin      = paddr_i == `PPAF_OFS_PIN;
   assign hit_ctrl     = paddr_i == `PPAF_OFS_CTRL;
   assign hit_state    = paddr_i == `PPAF_OFS_STATE;
   assign hit_any      = hit_dir | hit_out | hit_pin | hit_ctrl | hit_state;
   assign wr_en        = access_phase & pwrite_i & hit_any;

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h00000000;
      if (hit_dir)   rd_mux = {24'h000000, dir_reg};
      if (hit_out)   rd_mux = {24'h000000, out_reg};
      if (hit_pin)   rd_mux = {24'h000000, pin_sync_reg};
      if (hit_ctrl)  rd_mux = {29'h00000000, ctrl_reg};
      if (hit_state) rd_mux = {pad_oe_reg, pad_out_reg, pullup_reg, inen_reg};
   end

   always_comb begin
      case (apb_state_reg)
         PPAF_IDLE:   apb_state_next = setup_phase ? PPAF_ACCESS : PPAF_IDLE;
         PPAF_ACCESS: apb_state_next = setup_phase ? PPAF_ACCESS : PPAF_IDLE;
         default:     apb_state_next = PPAF_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         apb_state_reg <= PPAF_IDLE;
         pready_reg    <= 1'b0;
         pslverr_reg   <= 1'b0;
         prdata_reg    <= 32'h00000000;
      end else begin
         apb_state_reg <= apb_state_next;
         pready_reg    <= setup_phase;
         pslverr_reg   <= setup_phase & ~hit_any;
         prdata_reg    <= (setup_phase & ~pwrite_i) ? rd_mux : 32'h00000000;
      end
   end

   // port-wide write strobes for direction, output and control
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         dir_reg  <= `PPAF_RST_BYTE;
         out_reg  <= `PPAF_RST_BYTE;
         ctrl_reg <= 3'h0;
      end else if (wr_en) begin
         if (hit_dir)  dir_reg  <= pwdata_i[7:0];
         if (hit_out)  out_reg  <= pwdata_i[7:0];
         if (hit_ctrl) ctrl_reg <= pwdata_i[2:0];
      end
   end

   // pin-read synchroniser, port-wide
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pin_sync0_reg <= 8'h00;
         pin_sync_reg  <= 8'h00;
      end else begin
         pin_sync0_reg <= gated_in;
         pin_sync_reg  <= pin_sync0_reg;
      end
   end

   // registered pad controls; reset leaves pins tri-stated
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pad_out_reg <= 8'h00;
         pad_oe_reg  <= 8'h00;
         pullup_reg  <= 8'h00;
         inen_reg    <= 8'h00;
         di_reg      <= 8'h00;
      end else begin
         pad_out_reg <= res_val & res_oe;
         pad_oe_reg  <= res_oe;
         pullup_reg  <= res_pullup;
         inen_reg    <= res_inen;
         di_reg      <= gated_in;
      end
   end

   // analog path is outside this digital block: pad wires go straight to the pad
   assign pad_out_o                 = pad_out_reg;
   assign pad_oe_o                  = pad_oe_reg;
   assign pullup_en_o               = pullup_reg;
   assign input_en_o                = inen_reg;
   assign alt_function_digital_in_o = di_reg;
   assign xmem_data_in_o            = di_reg;
   assign prdata_o                  = prdata_reg;
   assign pready_o                  = pready_reg;
   assign pslverr_o                 = pslverr_reg;
endmodule

/* File: ppaf_xmem_model.sv */
// Purpose: external memory side, one address phase then one write phase
// Assumes: go_i is a one-cycle pulse
// Notes:   released lines show the inverse of their last value
`timescale 1ns/100ps
module ppaf_xmem_model (
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   input  wire logic       go_i,
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] data_i,
   output      logic       address_phase_active_o,
   output      logic       write_strobe_o,
   output      logic [7:0] addr_low_o,
   output      logic [7:0] data_out_o
);
   logic [1:0] ph_reg;
   always_ff @(posedge clk_i) begin
      ph_reg <= reset_i ? 2'b00 : {ph_reg[0], go_i};
   end
   assign address_phase_active_o = ph_reg[0];
   assign write_strobe_o         = ph_reg[1];
   assign addr_low_o             = ph_reg[0] ? addr_i : ~addr_i;
   assign data_out_o             = ph_reg[1] ? data_i : ~data_i;
endmodule

/* File: tb_top.sv */
// Purpose: self-checking bench of the pin override block
// Assumes: zero wait APB slave, outputs one cycle after inputs
// Notes:   each scenario is one task
`timescale 1ns/100ps
`include "ppaf_cfg.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; $display("Error %s exp %h got %h", n, e, g); end end
module tb_top;
   import ppaf_pkg::*;
   logic       clk_i = 1'b0, reset_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, sleep_i = 1'b0, go = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
   logic        pready_o, pslverr_o, err, xmem_write_strobe_i, address_phase_active_i;
   ppaf_byte_t  pad_out_o, pad_oe_o, pullup_en_o, input_en_o, alt_function_digital_in_o, xmem_data_in_o;
   ppaf_byte_t  xmem_addr_low_i, xmem_data_out_i, pad_in_i = 8'h00;
   ppaf_byte_t  pullup_override_enable_i = 8'h00, pullup_override_value_i = 8'h00;
   ppaf_byte_t  direction_override_enable_i = 8'h00, direction_override_value_i = 8'h00;
   ppaf_byte_t  pin_value_override_enable_i = 8'h00, pin_value_override_value_i = 8'h00;
   ppaf_byte_t  input_enable_override_enable_i = 8'h00, input_enable_override_value_i = 8'h00;
   int          num_errors = 0, num_checks = 0;
   ppaf_top ppaf_top_i (.*);
   ppaf_xmem_model ppaf_xmem_model_i (.clk_i, .reset_i, .go_i(go), .addr_i(8'hA5), .data_i(8'h5A),
      .address_phase_active_o(address_phase_active_i), .write_strobe_o(xmem_write_strobe_i),
      .addr_low_o(xmem_addr_low_i), .data_out_o(xmem_data_out_i));
   initial forever #10 clk_i = ~clk_i;
   task test_done;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel_i <= 1'b1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
      @(posedge clk_i) penable_i <= 1'b1;
      n = 0;
      do begin @(posedge clk_i); n++; end while (pready_o !== 1'b1 && n < 8);
      if (pready_o !== 1'b1) begin num_errors++; test_done(); end
      rd = prdata_o; err = pslverr_o;
      psel_i <= 1'b0; penable_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task rchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK("rdata", e, rd);
   endtask
   task pins(input ppaf_byte_t oe, out, pull, en);
      repeat (3) @(posedge clk_i);
      `CHK("oe", oe, pad_oe_o);
      `CHK("out", out, pad_out_o);
      `CHK("pullup", pull, pullup_en_o);
      `CHK("input_en", en, input_en_o);
   endtask
   task s_normal;
      rchk(`PPAF_OFS_CTRL, 32'h0);
      apb(1'b1, `PPAF_OFS_DIR, 32'h0F); apb(1'b1, `PPAF_OFS_OUT, 32'h3C);
      pins(8'h0F, 8'h0C, 8'h30, 8'hFF);
      rchk(`PPAF_OFS_STATE, 32'h0F0C30FF);
      apb(1'b1, `PPAF_OFS_CTRL, 32'h1); pins(8'h0F, 8'h0C, 8'h00, 8'hFF);
      apb(1'b1, `PPAF_OFS_CTRL, 32'h2); pins(8'h0F, 8'h0C, 8'h30, 8'h00);
      apb(1'b1, `PPAF_OFS_CTRL, 32'h0); pad_in_i <= 8'h96; pins(8'h0F, 8'h0C, 8'h30, 8'hFF);
      `CHK("din", 8'h96, alt_function_digital_in_o);
      rchk(`PPAF_OFS_PIN, 32'h96);
      apb(1'b1, 12'h014, 32'hFF); `CHK("slverr", 1'b1, err);
      rchk(12'h014, 32'h0);
   endtask
   task s_override;
      pullup_override_enable_i <= 8'hF0; pullup_override_value_i <= 8'hA0;
      direction_override_enable_i <= 8'hF0; direction_override_value_i <= 8'hA0;
      pin_value_override_enable_i <= 8'hF0; pin_value_override_value_i <= 8'hA0;
      input_enable_override_enable_i <= 8'hF0; input_enable_override_value_i <= 8'hA0;
      pins(8'hAF, 8'hAC, 8'hA0, 8'hAF);
      `CHK("din", 8'h86, alt_function_digital_in_o);
      sleep_i <= 1'b1; apb(1'b1, `PPAF_OFS_CTRL, 32'h1);
      pins(8'hAF, 8'hAC, 8'hA0, 8'hA0);
      sleep_i <= 1'b0;
   endtask
   task s_xmem;
      apb(1'b1, `PPAF_OFS_CTRL, 32'h4); pad_in_i <= 8'h69;
      pins(8'h00, 8'h00, 8'h3C, 8'hFF);
      `CHK("xdin", 8'h69, xmem_data_in_o);
      go <= 1'b1;
      @(posedge clk_i) go <= 1'b0;
      // bus phases change every cycle: read them mid-cycle where they have settled
      @(posedge clk_i);
      @(negedge clk_i);
      `CHK("oe", 8'hFF, pad_oe_o);
      `CHK("addr", 8'hA5, pad_out_o);
      `CHK("pu", 8'h00, pullup_en_o);
      @(negedge clk_i);
      `CHK("oe", 8'hFF, pad_oe_o);
      `CHK("data", 8'h5A, pad_out_o);
      @(negedge clk_i);
      `CHK("oe", 8'h00, pad_oe_o);
      `CHK("pu", 8'h3C, pullup_en_o);
      @(posedge clk_i);
   endtask
   task s_reset;
      reset_i <= 1'b1;
      pins(8'h00, 8'h00, 8'h00, 8'h00);
      `CHK("din", 8'h00, alt_function_digital_in_o);
      reset_i <= 1'b0;
      @(posedge clk_i);
      rchk(`PPAF_OFS_DIR, 32'h0);
      rchk(`PPAF_OFS_CTRL, 32'h0);
   endtask
   initial begin
      repeat (9) @(posedge clk_i);
      pins(8'h00, 8'h00, 8'h00, 8'h00);
      reset_i <= 1'b0;
      @(posedge clk_i);
      s_normal;
      s_override;
      s_xmem;
      s_reset;
      test_done;
   end
endmodule
